// ==== rtl/lfam_defs.vh ====
`ifndef LFAM_DEFS_VH
`define LFAM_DEFS_VH
// Byte offsets of the AXI4-Lite register map.
`define LFAM_OFS_CTRL 16'h0000
`define LFAM_OFS_STATUS 16'h0004
`define LFAM_OFS_ERR_CODE 16'h0008
`define LFAM_OFS_ERR_ID 16'h000C
`define LFAM_OFS_ALM_CODE 16'h0010
`define LFAM_OFS_ALM_ID 16'h0014
`define LFAM_OFS_DISC_CNT 16'h0018
`define LFAM_OFS_LIST_BASE 16'h5100
`define LFAM_OFS_LIST_LAST 16'h51FF
`define LFAM_OFS_MAP_BASE 16'h5200
`define LFAM_OFS_MAP_LAST 16'h527F
// Control register fields.
`define LFAM_CTRL_ERR_RESET 0
`define LFAM_CTRL_AUTO_REC 1
// Status register fields.
`define LFAM_ST_PAIR_SHORT 0
`define LFAM_ST_SUPPLY_SHORT 1
`define LFAM_ST_SUPPLY_DROP 2
`define LFAM_ST_DISCONNECT 3
`define LFAM_ST_ALARM 4
`define LFAM_ST_SLAVE_ALARM 5
`define LFAM_ST_TX_ENABLE 6
`define LFAM_ST_DUP_ALARM 7
// Alarm and error codes.
`define LFAM_CODE_PAIR_SHORT 16'h0CC9
`define LFAM_CODE_SUPPLY_SHORT 16'h0CCB
`define LFAM_CODE_DISCONNECT 16'h0D00
`define LFAM_CODE_DUP_ID 16'h0D90
`define LFAM_CODE_SUPPLY_DROP 16'h2500
`define LFAM_ID_LINE 16'h0FFF
// Reset values.
`define LFAM_RST_WORD 16'h0000
// AXI responses.
`define LFAM_RESP_OKAY 2'b00
`define LFAM_RESP_DECERR 2'b11
// Timing: clock rate, indicator period and input debounce time.
`define LFAM_CLK_HZ 10000000
`define LFAM_BLINK_PERIOD_MS 2000
`define LFAM_DEBOUNCE_US 1000
`endif

// ==== rtl/lfam_sync_filter.v ====
`timescale 1ns/10ps
// Three-stage synchroniser followed by a stability filter.
module lfam_sync_filter #(
  parameter STABLE_CYC = 10000
) (
  input wire aclk,
  input wire aresetn,
  input wire din,
  output reg dout
);
  localparam W = $clog2(STABLE_CYC + 1);
  localparam [W-1:0] LAST = STABLE_CYC - 1;
  reg s1;
  reg s2;
  reg s3;
  reg [W-1:0] cnt;

  // Only s2 reads s1; the filter compares the second and third stages.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      cnt <= {W{1'b0}};
      dout <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 != s3 || s3 == dout) begin
        cnt <= {W{1'b0}};
      end else if (cnt == LAST) begin
        dout <= s3;
        cnt <= {W{1'b0}};
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule // lfam_sync_filter

// ==== rtl/lfam_blinker.v ====
`timescale 1ns/10ps
// Square wave that toggles every HALF_CYC cycles while run is high.
module lfam_blinker #(
  parameter HALF_CYC = 10000000
) (
  input wire aclk,
  input wire aresetn,
  input wire run,
  output reg blink
);
  localparam W = $clog2(HALF_CYC + 1);
  localparam [W-1:0] LAST = HALF_CYC - 1;
  reg [W-1:0] cnt;

  // Parked at the last count, so a fresh alarm lights on the first tick.
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt <= LAST;
      blink <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= {W{1'b0}};
      blink <= ~blink;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // lfam_blinker

// ==== rtl/lfam_top.v ====
`timescale 1ns/10ps
`include "lfam_defs.vh"
// How it works
// - pair short sets flag, 0CC9H, 0FFFH
// - supply-data short sets flag, 0CCBH, stops link
// - short active flashes indicator, two-second period
// - transmission resumes once short disappears
// - shorts clear on reset or request off-edge
// - same-cycle alarms keep most recent only
// - lost module sets flag, 0D00H, its ID
// - count and list disconnected IDs
// - bitmap bit set per disconnected ID
// - disconnection never stops transmission
// - duplicate-ID modules never reported disconnected
// - only registered IDs are watched
// - disconnection clears by reset, request, detection
// - auto mode clears status, keeps latest words
// - auto recovery only for disconnection alarm
// - auto clear zeroes disconnection flag, count, list, bitmap
// - flags stay while any module lost
// - duplicate-ID alarm keeps slave alarm signal
// - supply drop sets flag, LED, 2500H, stops
// - drop clears by reset or remote reset
// - same-cycle errors keep most recent only
// - error reset clears alarm information
module lfam_top #(
  parameter ID_W = 6,
  parameter NUM_IDS = 64,
  parameter DEBOUNCE_CYC =
    `LFAM_CLK_HZ / 1000000 * `LFAM_DEBOUNCE_US,
  parameter BLINK_HALF_CYC =
    `LFAM_CLK_HZ / 1000 * `LFAM_BLINK_PERIOD_MS / 2
) (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire pair_short_in,
  input wire supply_short_in,
  input wire supply_drop_in,
  input wire lost_valid,
  input wire [ID_W-1:0] lost_id,
  input wire back_valid,
  input wire [ID_W-1:0] back_id,
  input wire dup_valid,
  input wire [ID_W-1:0] dup_id,
  input wire auto_detect_start,
  input wire reg_valid,
  input wire [ID_W-1:0] reg_id,
  input wire remote_reset,
  output reg line_pair_short_flag,
  output reg supply_data_short_flag,
  output reg supply_drop_flag,
  output reg disconnection_flag,
  output reg alarm_status_flag,
  output reg slave_alarm_signal,
  output reg tx_enable,
  output reg alarm_indicator,
  output reg error_indicator
);
  wire pair_s;
  wire supply_s;
  wire drop_s;
  wire blink;
  reg err_reset_req;
  reg err_reset_q;
  reg auto_mode;
  reg dup_alarm;
  reg [15:0] err_code;
  reg [15:0] err_id;
  reg [15:0] alm_code;
  reg [15:0] alm_id;
  reg [ID_W:0] disc_cnt;
  reg [NUM_IDS-1:0] registered;
  reg [NUM_IDS-1:0] dup_map;
  reg [NUM_IDS-1:0] lost_map;
  reg [NUM_IDS-1:0] still_lost;
  reg [ID_W-1:0] list_mem [0:NUM_IDS-1];
  reg [15:0] aw_addr;
  reg aw_held;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_held;
  reg [31:0] rd_word;
  reg rd_hit;
  integer i;
  integer j;
  integer idx;

  // Pins are synchronised and filtered before anything looks at them.
  lfam_sync_filter #(.STABLE_CYC(DEBOUNCE_CYC)) u_pair (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(pair_short_in),
    .dout(pair_s)
  );
  lfam_sync_filter #(.STABLE_CYC(DEBOUNCE_CYC)) u_supply (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(supply_short_in),
    .dout(supply_s)
  );
  lfam_sync_filter #(.STABLE_CYC(DEBOUNCE_CYC)) u_drop (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(supply_drop_in),
    .dout(drop_s)
  );

  // One blinker serves shorts and disconnection alike.
  lfam_blinker #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(line_pair_short_flag | supply_data_short_flag |
         disconnection_flag),
    .blink(blink)
  );

  // Clearing conditions; the request clears on its falling edge.
  wire err_clr = err_reset_q & ~err_reset_req;
  wire lost_ok = lost_valid & registered[lost_id] &
                 ~dup_map[lost_id];
  wire lost_new = lost_ok & ~lost_map[lost_id];
  wire auto_clr = auto_mode & disconnection_flag & ~lost_ok &
                  (still_lost == {NUM_IDS{1'b0}});
  wire disc_clr = err_clr | auto_detect_start | auto_clr;
  wire drop_clr = remote_reset & ~drop_s;

  // Next values of alarm and error state.
  reg next_pair;
  reg next_supply;
  reg next_drop;
  reg next_disc;
  reg next_dup;
  reg [15:0] next_alm_code;
  reg [15:0] next_alm_id;
  reg [15:0] next_err_code;
  reg [15:0] next_err_id;
  always @* begin
    next_pair = line_pair_short_flag & ~err_clr;
    next_supply = supply_data_short_flag & ~err_clr;
    next_drop = supply_drop_flag & ~drop_clr;
    next_disc = disconnection_flag & ~disc_clr;
    next_dup = dup_alarm & ~(err_clr | auto_detect_start);
    next_alm_code = err_clr ? `LFAM_RST_WORD : alm_code;
    next_alm_id = err_clr ? `LFAM_RST_WORD : alm_id;
    next_err_code = drop_clr ? `LFAM_RST_WORD : err_code;
    next_err_id = drop_clr ? `LFAM_RST_WORD : err_id;
    // Later sources override earlier ones, so the newest wins.
    if (pair_s && !line_pair_short_flag) begin
      next_pair = 1'b1;
      next_alm_code = `LFAM_CODE_PAIR_SHORT;
      next_alm_id = `LFAM_ID_LINE;
    end
    if (supply_s && !supply_data_short_flag) begin
      next_supply = 1'b1;
      next_alm_code = `LFAM_CODE_SUPPLY_SHORT;
      next_alm_id = `LFAM_ID_LINE;
    end
    if (dup_valid) begin
      next_dup = 1'b1;
      next_alm_code = `LFAM_CODE_DUP_ID;
      next_alm_id = {{(16-ID_W){1'b0}}, dup_id};
    end
    if (lost_ok) begin
      next_disc = 1'b1;
      next_alm_code = `LFAM_CODE_DISCONNECT;
      next_alm_id = {{(16-ID_W){1'b0}}, lost_id};
    end
    if (drop_s && !supply_drop_flag) begin
      next_drop = 1'b1;
      next_err_code = `LFAM_CODE_SUPPLY_DROP;
      next_err_id = `LFAM_ID_LINE;
    end
  end

  // Flags, code words and the link devices that follow them.
  always @(posedge aclk) begin
    if (!aresetn) begin
      line_pair_short_flag <= 1'b0;
      supply_data_short_flag <= 1'b0;
      supply_drop_flag <= 1'b0;
      disconnection_flag <= 1'b0;
      dup_alarm <= 1'b0;
      alarm_status_flag <= 1'b0;
      slave_alarm_signal <= 1'b0;
      tx_enable <= 1'b0;
      alarm_indicator <= 1'b0;
      error_indicator <= 1'b0;
      alm_code <= `LFAM_RST_WORD;
      alm_id <= `LFAM_RST_WORD;
      err_code <= `LFAM_RST_WORD;
      err_id <= `LFAM_RST_WORD;
      err_reset_q <= 1'b0;
    end else begin
      line_pair_short_flag <= next_pair;
      supply_data_short_flag <= next_supply;
      supply_drop_flag <= next_drop;
      disconnection_flag <= next_disc;
      dup_alarm <= next_dup;
      alarm_status_flag <= next_pair | next_supply | next_disc |
                           next_dup;
      slave_alarm_signal <= next_disc | next_dup;
      // Disconnection is deliberately absent here.
      tx_enable <= ~(pair_s | supply_s | next_drop);
      alarm_indicator <= blink;
      error_indicator <= next_drop;
      alm_code <= next_alm_code;
      alm_id <= next_alm_id;
      err_code <= next_err_code;
      err_id <= next_err_id;
      err_reset_q <= err_reset_req;
    end
  end

  // Registration, duplicate marks, disconnected list, bitmap and count.
  always @(posedge aclk) begin
    if (!aresetn) begin
      registered <= {NUM_IDS{1'b0}};
      dup_map <= {NUM_IDS{1'b0}};
      lost_map <= {NUM_IDS{1'b0}};
      still_lost <= {NUM_IDS{1'b0}};
      disc_cnt <= {(ID_W+1){1'b0}};
      for (i = 0; i < NUM_IDS; i = i + 1) begin
        list_mem[i] <= {ID_W{1'b0}};
      end
    end else begin
      if (auto_detect_start) begin
        registered <= {NUM_IDS{1'b0}};
      end
      // A registration in the detection start cycle is kept.
      if (reg_valid) begin
        registered[reg_id] <= 1'b1;
      end
      if (err_clr || auto_detect_start) begin
        dup_map <= {NUM_IDS{1'b0}};
      end
      if (dup_valid) begin
        dup_map[dup_id] <= 1'b1;
      end
      if (disc_clr) begin
        lost_map <= {NUM_IDS{1'b0}};
        still_lost <= {NUM_IDS{1'b0}};
        disc_cnt <= {(ID_W+1){1'b0}};
        for (i = 0; i < NUM_IDS; i = i + 1) begin
          list_mem[i] <= {ID_W{1'b0}};
        end
      end
      if (back_valid) begin
        still_lost[back_id] <= 1'b0;
      end
      // A loss in the clearing cycle is kept: set wins over clear.
      if (lost_ok) begin
        still_lost[lost_id] <= 1'b1;
      end
      if (lost_new) begin
        lost_map[lost_id] <= 1'b1;
        if (disc_clr) begin
          disc_cnt <= {{ID_W{1'b0}}, 1'b1};
          list_mem[0] <= lost_id;
        end else begin
          disc_cnt <= disc_cnt + 1'b1;
          list_mem[disc_cnt[ID_W-1:0]] <= lost_id;
        end
      end
    end
  end

  // Read decode; unmapped byte addresses answer DECERR.
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    idx = 0;
    j = 0;
    if (s_axi_araddr >= `LFAM_OFS_LIST_BASE &&
        s_axi_araddr <= `LFAM_OFS_LIST_LAST) begin
      idx = s_axi_araddr[15:2] - (`LFAM_OFS_LIST_BASE >> 2);
      if (idx < NUM_IDS) begin
        rd_word[ID_W-1:0] = list_mem[idx];
      end
    end else if (s_axi_araddr >= `LFAM_OFS_MAP_BASE &&
                 s_axi_araddr <= `LFAM_OFS_MAP_LAST) begin
      idx = (s_axi_araddr[15:2] - (`LFAM_OFS_MAP_BASE >> 2)) * 16;
      for (j = 0; j < 16; j = j + 1) begin
        if (idx + j < NUM_IDS) begin
          rd_word[j] = lost_map[idx + j];
        end
      end
    end else begin
      case (s_axi_araddr)
        `LFAM_OFS_CTRL: begin
          rd_word[`LFAM_CTRL_ERR_RESET] = err_reset_req;
          rd_word[`LFAM_CTRL_AUTO_REC] = auto_mode;
        end
        `LFAM_OFS_STATUS: begin
          rd_word[`LFAM_ST_PAIR_SHORT] = line_pair_short_flag;
          rd_word[`LFAM_ST_SUPPLY_SHORT] = supply_data_short_flag;
          rd_word[`LFAM_ST_SUPPLY_DROP] = supply_drop_flag;
          rd_word[`LFAM_ST_DISCONNECT] = disconnection_flag;
          rd_word[`LFAM_ST_ALARM] = alarm_status_flag;
          rd_word[`LFAM_ST_SLAVE_ALARM] = slave_alarm_signal;
          rd_word[`LFAM_ST_TX_ENABLE] = tx_enable;
          rd_word[`LFAM_ST_DUP_ALARM] = dup_alarm;
        end
        `LFAM_OFS_ERR_CODE: rd_word[15:0] = err_code;
        `LFAM_OFS_ERR_ID: rd_word[15:0] = err_id;
        `LFAM_OFS_ALM_CODE: rd_word[15:0] = alm_code;
        `LFAM_OFS_ALM_ID: rd_word[15:0] = alm_id;
        `LFAM_OFS_DISC_CNT: rd_word[ID_W:0] = disc_cnt;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // Read channel: one read in flight; data follows the address handshake.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LFAM_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `LFAM_RESP_OKAY : `LFAM_RESP_DECERR;
      end
    end
  end

  // Write channel: address and data held apart, then committed together.
  wire wr_go = aw_held & w_held & ~s_axi_bvalid;
  wire wr_mapped = (aw_addr == `LFAM_OFS_CTRL) ||
    (aw_addr == `LFAM_OFS_STATUS) || (aw_addr == `LFAM_OFS_ERR_CODE) ||
    (aw_addr == `LFAM_OFS_ERR_ID) || (aw_addr == `LFAM_OFS_ALM_CODE) ||
    (aw_addr == `LFAM_OFS_ALM_ID) || (aw_addr == `LFAM_OFS_DISC_CNT) ||
    (aw_addr >= `LFAM_OFS_LIST_BASE && aw_addr <= `LFAM_OFS_MAP_LAST);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LFAM_RESP_OKAY;
      aw_addr <= 16'h0000;
      aw_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      err_reset_req <= 1'b0;
      auto_mode <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !aw_held && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && !w_held && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Only the control word is writable; other mapped words ignore it.
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `LFAM_RESP_OKAY : `LFAM_RESP_DECERR;
        if (aw_addr == `LFAM_OFS_CTRL && w_strb[0]) begin
          err_reset_req <= w_data[`LFAM_CTRL_ERR_RESET];
          auto_mode <= w_data[`LFAM_CTRL_AUTO_REC];
        end
      end
    end
  end
endmodule // lfam_top

// ==== sim/lfam_properties.sv ====
`timescale 1ns/10ps
// Watches bus handshakes and fault outputs of the monitor.
module lfam_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire line_pair_short_flag,
  input wire supply_drop_flag,
  input wire disconnection_flag,
  input wire alarm_status_flag,
  input wire tx_enable,
  input wire alarm_indicator
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Two cycles of drop flag cover either latency of the link stop.
  property p_drop_stop;
    supply_drop_flag && $past(supply_drop_flag) |-> !tx_enable;
  endproperty
  a_drop_stop: assert property (p_drop_stop)
    else $error("link running during supply drop");
  property p_disc_keep_tx;
    $rose(disconnection_flag) && $past(tx_enable) |-> tx_enable;
  endproperty
  a_disc_keep_tx: assert property (p_disc_keep_tx)
    else $error("link stopped by a disconnection");
  // A fall while the short persists ends a full eight-cycle high phase.
  property p_blink;
    $fell(alarm_indicator) && line_pair_short_flag |->
      $past(alarm_indicator, 8) && !$past(alarm_indicator, 9);
  endproperty
  a_blink: assert property (p_blink)
    else $error("indicator high phase has wrong length");
  property p_disc_alarm;
    disconnection_flag |-> alarm_status_flag;
  endproperty
  a_disc_alarm: assert property (p_disc_alarm)
    else $error("alarm status low while disconnected");
  property p_ar_ans;
    $rose(s_axi_arvalid) && !s_axi_rvalid |=> s_axi_arready ##1 s_axi_rvalid;
  endproperty
  a_ar_ans: assert property (p_ar_ans)
    else $error("read address not answered next cycle");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped before taken");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before taken");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("write response late");
endmodule // lfam_properties

// ==== sim/lfam_field_model.sv ====
`timescale 1ns/10ps
// Field side: sense pins and slave module events on the line.
module lfam_field_model (
  input wire aclk,
  output reg pair_short_in,
  output reg supply_short_in,
  output reg supply_drop_in,
  output wire lost_valid,
  output wire [5:0] lost_id,
  output wire back_valid,
  output wire [5:0] back_id,
  output wire dup_valid,
  output wire [5:0] dup_id,
  output wire reg_valid,
  output wire [5:0] reg_id,
  output wire auto_detect_start
);
  reg [4:0] vld = 5'h00;
  reg [5:0] idv = 6'h00;
  initial begin
    {pair_short_in, supply_short_in, supply_drop_in} = 3'b000;
  end
  // One id bus serves all events, since only one is ever raised at a time.
  assign {auto_detect_start, reg_valid, dup_valid, back_valid} = vld[4:1];
  assign lost_valid = vld[0];
  assign lost_id = idv;
  assign back_id = idv;
  assign dup_id = idv;
  assign reg_id = idv;
  // Sense pins change just after an edge; the synchroniser absorbs it.
  task pins(input logic [2:0] v);
    @(posedge aclk);
    {supply_drop_in, supply_short_in, pair_short_in} <= v;
  endtask
  // Kinds: 0 lost, 1 back, 2 dup, 3 registered, 4 detection start.
  // The id is inverted once stale so it never passes for valid data.
  task ev(input int kind, input logic [5:0] id);
    @(posedge aclk);
    vld <= 5'(1 << kind);
    idv <= id;
    @(posedge aclk);
    vld <= 5'h00;
    idv <= ~id;
  endtask
endmodule // lfam_field_model

// ==== sim/testbench.sv ====
`timescale 1ns/10ps
`include "lfam_defs.vh"
module testbench;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [15:0] s_axi_awaddr = 16'h0000;
  reg [15:0] s_axi_araddr = 16'h0000;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg [3:0] s_axi_wstrb = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, remote_reset = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, pair_short_in, supply_short_in, supply_drop_in;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire lost_valid, back_valid, dup_valid, reg_valid, auto_detect_start;
  wire [5:0] lost_id, back_id, dup_id, reg_id;
  wire line_pair_short_flag, supply_data_short_flag, supply_drop_flag;
  wire disconnection_flag, alarm_status_flag, slave_alarm_signal;
  wire tx_enable, alarm_indicator, error_indicator;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [3:0] strb = 4'hF;
  // Short counts keep the run brief; expectations follow from these.
  lfam_top #(.DEBOUNCE_CYC(4), .BLINK_HALF_CYC(8)) i_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pair_short_in, .supply_short_in, .supply_drop_in, .lost_valid,
    .lost_id, .back_valid, .back_id, .dup_valid, .dup_id,
    .auto_detect_start, .reg_valid, .reg_id, .remote_reset,
    .line_pair_short_flag, .supply_data_short_flag, .supply_drop_flag,
    .disconnection_flag, .alarm_status_flag, .slave_alarm_signal,
    .tx_enable, .alarm_indicator, .error_indicator);
  lfam_field_model i_field (.aclk, .pair_short_in, .supply_short_in,
    .supply_drop_in, .lost_valid, .lost_id, .back_valid, .back_id,
    .dup_valid, .dup_id, .reg_valid, .reg_id, .auto_detect_start);
  initial begin
    forever #50 aclk = ~aclk;
  end
  // A hang counts as a mismatch and closes the run.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  task chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Address and data go out together; each drops once its ready is seen.
  task axi_wr(input logic [15:0] a, input logic [31:0] d);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready) aw_ok = 1;
      if (s_axi_wready) w_ok = 1;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    // Bready stands until the response is sampled.
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  // Remote reset is a one-cycle pulse: raised, then inverted back.
  task rrst;
    @(posedge aclk);
    remote_reset <= ~remote_reset;
    @(posedge aclk);
    remote_reset <= ~remote_reset;
  endtask
  task axi_rd(input logic [15:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task rc(input string w, input logic [15:0] a, input logic [31:0] m, e);
    axi_rd(a);
    chk(w, rd & m, e);
  endtask
  task err_reset(input logic [31:0] h);
    axi_wr(`LFAM_OFS_CTRL, 32'h0000_0001);
    rc("held", `LFAM_OFS_STATUS, 32'h0000_000F, h);
    axi_wr(`LFAM_OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge aclk);
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Slave module events: registration, duplicate, losses and returns.
  task disc_part;
    i_field.ev(4, 6'd0);
    i_field.ev(3, 6'd5);
    i_field.ev(3, 6'd20);
    i_field.ev(3, 6'd33);
    i_field.ev(2, 6'd33);
    i_field.ev(0, 6'd5);
    i_field.ev(0, 6'd20);
    i_field.ev(0, 6'd33);
    i_field.ev(0, 6'd7);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0058, 32'h0000_0058);
    rc("alm_code", `LFAM_OFS_ALM_CODE, 32'hFFFF, 32'h0D00);
    rc("alm_id", `LFAM_OFS_ALM_ID, 32'hFFFF, 32'h0014);
    rc("count", `LFAM_OFS_DISC_CNT, 32'hFFFF, 32'h0002);
    rc("list0", 16'h5100, 32'hFFFF, 32'h0005);
    rc("list1", 16'h5104, 32'hFFFF, 32'h0014);
    rc("map0", 16'h5200, 32'hFFFF, 32'h0020);
    rc("map1", 16'h5204, 32'hFFFF, 32'h0010);
    rc("map2", 16'h5208, 32'hFFFF, 32'h0000);
    axi_wr(`LFAM_OFS_CTRL, 32'h0000_0002);
    i_field.ev(1, 6'd5);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0018, 32'h0000_0018);
    i_field.ev(1, 6'd20);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_00A8, 32'h0000_00A0);
    rc("count", `LFAM_OFS_DISC_CNT, 32'hFFFF, 32'h0000);
    rc("list1", 16'h5104, 32'hFFFF, 32'h0000);
    rc("map1", 16'h5204, 32'hFFFF, 32'h0000);
    chk("alm_led", {31'h0, alarm_indicator}, 32'h0);
    rc("alm_id", `LFAM_OFS_ALM_ID, 32'hFFFF, 32'h0014);
    i_field.ev(4, 6'd0);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_00A8, 32'h0000_0000);
    i_field.ev(0, 6'd5);
    rc("count", `LFAM_OFS_DISC_CNT, 32'hFFFF, 32'h0000);
    axi_wr(`LFAM_OFS_CTRL, 32'h0000_0000);
    i_field.ev(3, 6'd9);
    i_field.ev(0, 6'd9);
    err_reset(32'h0000_0008);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0008, 32'h0000_0000);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl", `LFAM_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rc("status", `LFAM_OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0040);
    axi_rd(16'h0100);
    chk("resp", {30'h0, rr}, {30'h0, `LFAM_RESP_DECERR});
    strb = 4'hE;
    axi_wr(`LFAM_OFS_CTRL, 32'h0000_0003);
    strb = 4'hF;
    rc("ctrl_strb", `LFAM_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    i_field.pins(3'b001);
    repeat (20) @(posedge aclk);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0041, 32'h0000_0001);
    rc("alm_code", `LFAM_OFS_ALM_CODE, 32'hFFFF, 32'h0CC9);
    rc("alm_id", `LFAM_OFS_ALM_ID, 32'hFFFF, 32'h0FFF);
    i_field.pins(3'b011);
    repeat (20) @(posedge aclk);
    rc("alm_code", `LFAM_OFS_ALM_CODE, 32'hFFFF, 32'h0CCB);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0043, 32'h0000_0003);
    i_field.pins(3'b000);
    repeat (20) @(posedge aclk);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0043, 32'h0000_0043);
    err_reset(32'h0000_0003);
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0003, 32'h0000_0000);
    rc("alm_code", `LFAM_OFS_ALM_CODE, 32'hFFFF, 32'h0000);
    i_field.pins(3'b100);
    repeat (20) @(posedge aclk);
    rc("err_code", `LFAM_OFS_ERR_CODE, 32'hFFFF, 32'h2500);
    rc("err_id", `LFAM_OFS_ERR_ID, 32'hFFFF, 32'h0FFF);
    chk("err_led", {31'h0, error_indicator}, 32'h1);
    err_reset(32'h0000_0004);
    rrst();
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0044, 32'h0000_0004);
    i_field.pins(3'b000);
    repeat (20) @(posedge aclk);
    rrst();
    rc("status", `LFAM_OFS_STATUS, 32'h0000_0044, 32'h0000_0040);
    rc("err_code", `LFAM_OFS_ERR_CODE, 32'hFFFF, 32'h0000);
    chk("err_led", {31'h0, error_indicator}, 32'h0);
    disc_part();
    results();
  end
endmodule // testbench
bind lfam_top lfam_properties i_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .line_pair_short_flag,
  .supply_drop_flag, .disconnection_flag, .alarm_status_flag, .tx_enable,
  .alarm_indicator);
